// ==== design/pin_func_defines.svh ====
/*
  Register offsets, field positions and reset values of the port B / port C
  pin-function select block. Assumes inclusion by bare name.
*/
`ifndef PIN_FUNC_DEFINES_SVH
`define PIN_FUNC_DEFINES_SVH

// Byte offsets on the APB bus (one aligned word each)
`define OFS_PB_LOW       12'h000
`define OFS_PB_HIGH      12'h004
`define OFS_PC_LOW       12'h008
`define OFS_PC_HIGH      12'h00c
`define OFS_RST_CTRL     12'h010
`define OFS_STATUS       12'h014

// Reset value of every select register
`define SEL_RESET        8'h00
// Reset value of the reset-pin control register (external reset off)
`define RST_CTRL_RESET   8'h00
// Bit of the reset-pin control register that enables the external reset
`define RST_CTRL_EN_BIT  0

// Writable masks
`define MASK_PB_HIGH_SMALL 8'hcf
`define MASK_PC_HIGH       8'h0f
`define MASK_ALL           8'hff

// Field encodings that pick the alternate function (11) and the option (10)
`define SEL_ALT          2'h3
`define SEL_OPT          2'h2

`endif

// ==== design/pin_func_pkg.sv ====
/*
  Types for the pin-function select block. Assumes the defines header sits
  beside it.
*/
`default_nettype none
package pin_func_pkg;
  // Route chosen for one pad
  typedef enum logic [1:0] {RouteGpio, RouteOpt, RouteAlt} route_e;
  // One two-bit select field
  typedef logic [1:0] field_t;
endpackage
`default_nettype wire

// ==== design/pin_field_decode.sv ====
/*
  Decodes one two-bit select field into the pad route. Assumes the caller
  supplies whether code 10 has its own function on this pin.
*/
`default_nettype none
`include "pin_func_defines.svh"
module pin_field_decode
  import pin_func_pkg::*;
(
  // Field and options
  input  wire pin_func_pkg::field_t field,
  input  wire logic                 optUsed,
  // Route out
  output logic [1:0]                route
);
  // Code 11 picks the alternate; 10 picks the option only where it exists
  assign route = (field == `SEL_ALT) ? 2'h2 :
                 ((field == `SEL_OPT) && optUsed) ? 2'h1 : 2'h0;
endmodule
`default_nettype wire

// ==== design/pin_func_regs.sv ====
/*
  Register holding one raw select byte under a per-register write mask, for the APB slave.
  Assumes one clock, synchronous active-low reset.
*/
`default_nettype none
`include "pin_func_defines.svh"
module pin_func_regs
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Write strobe and data
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrData,
  input  wire logic [7:0]  wrMask,
  // Stored value
  output logic [7:0]       value
);
  // Masked bits never change, so they stay at their reset value of zero
  always_ff @(posedge clock)
  begin
    if (!resetn)
      value <= `SEL_RESET;
    else if (wrEn)
      value <= (value & ~wrMask) | (wrData & wrMask);
  end
endmodule
`default_nettype wire

// ==== design/port_b_c_pin_function_select.sv ====
/*
  Pin-function select for port B high/low and port C, with APB register
  access and registered pad route outputs. Assumes an APB master on the same
  clock; the SMALL parameter picks the small device variant.
*/
`default_nettype none
`include "pin_func_defines.svh"
// Behaviour
// - PB7: 11 analog, else general I/O
// - Reset pin enable overrides PB7 field
// - Small: port B high bits 5:4 read zero
// - Small PB5: 10 inverted compact timer, 11 analog two
// - Small PB4: 10 inverted periodic timer, 11 analog one
// - Large PB4: 10 inverted periodic timer, 11 analog four
// - PC3: 11 serial clock
// - PC2: 11 serial data out / transmit
// - PC1: 11 serial data in / receive
// - PC0: 11 chip select
// - PC5: 11 crystal pin a
// - PC4: 11 crystal pin b
// - Port C high bits 7:4 read zero, ignored
module port_b_c_pin_function_select
  import pin_func_pkg::*;
#(
  parameter bit SMALL = 1'b1
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pad routes: two bits per pin, 0 general I/O, 1 option, 2 alternate
  output logic [15:0]      portBRoute,
  output logic [11:0]      portCRoute,
  // PB7 acts as external reset input
  output logic             pb7ExternalReset
);
  import pin_func_pkg::*;

  // Raw register contents
  logic [7:0] portBLowFuncSelect;
  logic [7:0] portBHighFuncSelect;
  logic [7:0] portCLowFuncSelect;
  logic [7:0] portCHighFuncSelect;
  logic [7:0] resetPinControlRegister;

  // Access phase decode: single-cycle answer, pready high in the access cycle only
  wire        access  = psel && penable;
  wire        wrAcc   = access && pwrite;
  wire        hitPbLo = (paddr == `OFS_PB_LOW);
  wire        hitPbHi = (paddr == `OFS_PB_HIGH);
  wire        hitPcLo = (paddr == `OFS_PC_LOW);
  wire        hitPcHi = (paddr == `OFS_PC_HIGH);
  wire        hitRst  = (paddr == `OFS_RST_CTRL);
  wire        hitStat = (paddr == `OFS_STATUS);
  wire        mapped  = hitPbLo | hitPbHi | hitPcLo | hitPcHi | hitRst | hitStat;

  // Small variant has no bits 5:4 in port B high; port C high has only 3:0
  wire [7:0]  pbHiMask = SMALL ? `MASK_PB_HIGH_SMALL : `MASK_ALL;
  wire [7:0]  pcHiMask = `MASK_PC_HIGH;

  // Select registers, all cleared at reset
  pin_func_regs uPbLo (.clock(clock), .resetn(resetn), .wrEn(wrAcc && hitPbLo),
    .wrData(pwdata[7:0]), .wrMask(`MASK_ALL), .value(portBLowFuncSelect));
  pin_func_regs uPbHi (.clock(clock), .resetn(resetn), .wrEn(wrAcc && hitPbHi),
    .wrData(pwdata[7:0]), .wrMask(pbHiMask), .value(portBHighFuncSelect));
  pin_func_regs uPcLo (.clock(clock), .resetn(resetn), .wrEn(wrAcc && hitPcLo),
    .wrData(pwdata[7:0]), .wrMask(`MASK_ALL), .value(portCLowFuncSelect));
  pin_func_regs uPcHi (.clock(clock), .resetn(resetn), .wrEn(wrAcc && hitPcHi),
    .wrData(pwdata[7:0]), .wrMask(pcHiMask), .value(portCHighFuncSelect));
  pin_func_regs uRst (.clock(clock), .resetn(resetn), .wrEn(wrAcc && hitRst),
    .wrData(pwdata[7:0]), .wrMask(`MASK_ALL), .value(resetPinControlRegister));

  // External reset enable from the reset-pin control register
  wire        extResetEn = resetPinControlRegister[`RST_CTRL_EN_BIT];

  // Per-pin decode; which pins use code 10 depends on the variant
  // Port B pins 0..7: low register holds PB0..PB3, high holds PB4..PB7
  wire [15:0] pbFields = {portBHighFuncSelect, portBLowFuncSelect};
  wire [7:0]  pbOpt    = SMALL ? 8'h30 : 8'h10; // PB4 both, PB5 small only
  logic [15:0] pbRouteRaw;
  logic [11:0] pcRouteRaw;
  // Port C pins 0..5: low holds PC0..PC3, high holds PC4..PC5
  wire [11:0] pcFields = {portCHighFuncSelect[3:0], portCLowFuncSelect};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : gPb
      // PB4: 10 inverted periodic timer, 11 analog
      // PB5 small: 10 inverted compact timer, 11 analog
      pin_field_decode uDec (
        .field  (pbFields[2*gi +: 2]),
        .optUsed(pbOpt[gi]),
        .route  (pbRouteRaw[2*gi +: 2])
      );
    end
    for (gi = 0; gi < 6; gi++)
    begin : gPc
      // 11 gives serial or crystal function, else general I/O
      pin_field_decode uDec (
        .field  (pcFields[2*gi +: 2]),
        .optUsed(1'b0),
        .route  (pcRouteRaw[2*gi +: 2])
      );
    end
  endgenerate

  // PB7 route: analog on 11 only, forced to general I/O when reset pin on
  wire [1:0]  pb7Route = extResetEn ? 2'h0 : pbRouteRaw[15:14];
  wire [15:0] next_portBRoute = {pb7Route, pbRouteRaw[13:0]};

  // Read mux; unimplemented bits are zero since the registers hold zero
  wire [7:0]  statusByte = {6'h00, SMALL, extResetEn};
  wire [7:0]  rdByte =
      hitPbLo ? portBLowFuncSelect  :
      hitPbHi ? portBHighFuncSelect :
      hitPcLo ? portCLowFuncSelect  :
      hitPcHi ? portCHighFuncSelect :
      hitRst  ? resetPinControlRegister :
      hitStat ? statusByte : 8'h00;
  wire [31:0] next_prdata  = (psel && !penable && !pwrite) ? {24'h000000, rdByte}
                                                           : prdata;
  wire        next_pslverr = psel && !penable && !mapped;

  // Bus answer registers; read data captured in setup, shown in access
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
      pready  <= psel && !penable;
    end
  end

  // Routes follow the registers one cycle later
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      portBRoute       <= 16'h0000;
      portCRoute       <= 12'h000;
      pb7ExternalReset <= 1'b0;
    end
    else
    begin
      portBRoute       <= next_portBRoute;
      portCRoute       <= pcRouteRaw;
      pb7ExternalReset <= extResetEn;
    end
  end
endmodule
`default_nettype wire

// ==== verification/port_b_c_pin_function_select_sva.sv ====
/* Checker for the port B / port C pin-function select block.
   Sees only the top module ports; bound to every instance below. */
`default_nettype none
module port_b_c_pin_function_select_sva #(
  parameter bit SMALL = 1'b1
)
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pad routes
  input wire logic [15:0] portBRoute,
  input wire logic [11:0] portCRoute,
  input wire logic        pb7ExternalReset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Accepted write at the access edge
  wire logic wrAcc = psel && penable && pwrite && pready;
  // Only code 11 selects the alternate function
  function automatic logic [1:0] f2(input logic [1:0] f);
    return (f == 2'h3) ? 2'h2 : 2'h0;
  endfunction
  // Code 10 picks the option, 11 the alternate
  function automatic logic [1:0] f3(input logic [1:0] f);
    return (f == 2'h3) ? 2'h2 : (f == 2'h2) ? 2'h1 : 2'h0;
  endfunction
  reset_clear_a:
    assert property (disable iff (1'b0) !resetn |=> portBRoute == 16'h0000
      && portCRoute == 12'h000 && !pb7ExternalReset) else $error("Routes not clear");
  pb7_override_a:
    assert property (pb7ExternalReset && $past(pb7ExternalReset) |-> portBRoute[15:14] == 2'h0)
      else $error("PB7 not overridden");
  pb7_route_a:
    assert property (portBRoute[14] == 1'b0) else $error("PB7 option route");
  pc_codes_a:
    assert property ((portCRoute & 12'h555) == 12'h000) else $error("Port C option route");
  pb_high_read_a:
    assert property (pready && !pwrite && paddr == 12'h004 && SMALL |-> prdata[5:4] == 2'h0)
      else $error("Port B high bits 5:4 set");
  pc_high_read_a:
    assert property (pready && !pwrite && paddr == 12'h00c |-> prdata[7:4] == 4'h0)
      else $error("Port C high bits 7:4 set");
  pc_route_a:
    assert property (wrAcc && paddr == 12'h008 |=> ##1 portCRoute[7:0] == {f2($past(pwdata[7:6], 2)),
      f2($past(pwdata[5:4], 2)), f2($past(pwdata[3:2], 2)), f2($past(pwdata[1:0], 2))})
      else $error("Port C route wrong");
  pb_route_a:
    assert property (wrAcc && paddr == 12'h004 |=> ##1
      portBRoute[11:8] == {(SMALL ? f3($past(pwdata[3:2], 2)) : f2($past(pwdata[3:2], 2))),
      f3($past(pwdata[1:0], 2))})
      else $error("PB4 or PB5 route wrong");
  cover property (wrAcc && paddr == 12'h004);
  cover property (pb7ExternalReset);
  cover property (pready && pslverr);
endmodule
bind port_b_c_pin_function_select port_b_c_pin_function_select_sva #(.SMALL(SMALL)) i_sva (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .portBRoute(portBRoute), .portCRoute(portCRoute), .pb7ExternalReset(pb7ExternalReset));
`default_nettype wire

// ==== verification/port_b_c_pin_function_select_test.sv ====
/* Self-checking bench for the pin-function select block.
   Assumes the small variant and one-wait-free APB slave timing. */
`default_nettype none
module port_b_c_pin_function_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, pb7ExternalReset;
  logic [15:0] portBRoute;
  logic [11:0] portCRoute;
  logic [7:0]  b, l, h, p;
  // Larger variant watched side by side; its bus answers are not compared
  logic [15:0] bRouteLarge;
  int          fails = 0, checkCount = 0;
  always #5 clock = ~clock;
  port_b_c_pin_function_select #(.SMALL(1'b1)) i_port_b_c_pin_function_select (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portBRoute(portBRoute), .portCRoute(portCRoute), .pb7ExternalReset(pb7ExternalReset));
  port_b_c_pin_function_select #(.SMALL(1'b0)) i_port_b_c_pin_function_select_large (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .portBRoute(bRouteLarge), .portCRoute(), .pb7ExternalReset());
  // Verdict and end of run
  task automatic finishTest;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // One APB transfer; an idle cycle follows so psel is never driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        fails++;
        finishTest();
      end
      @(posedge clock);
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [1:0] f2(input logic [1:0] f);
    return (f == 2'h3) ? 2'h2 : 2'h0;
  endfunction
  function automatic logic [1:0] f3(input logic [1:0] f);
    return (f == 2'h3) ? 2'h2 : (f == 2'h2) ? 2'h1 : 2'h0;
  endfunction
  // Compare routes with the last values written, once they have settled
  task automatic routes(input logic ov);
    logic [11:0] ec;
    ec = {f2(h[3:2]), f2(h[1:0]), f2(l[7:6]), f2(l[5:4]), f2(l[3:2]), f2(l[1:0])};
    @(posedge clock);
    @(negedge clock);
    chk({ov ? 2'h0 : f2(b[7:6]), 2'h0, f3(b[3:2]), f3(b[1:0])}, portBRoute[15:8]);
    chk(ec, portCRoute);
    chk(ov, pb7ExternalReset);
    chk({f2(p[7:6]), f2(p[5:4]), f2(p[3:2]), f2(p[1:0])}, portBRoute[7:0]);
    chk({ov ? 2'h0 : f2(b[7:6]), f2(b[5:4]), f2(b[3:2]), f3(b[1:0])}, bRouteLarge[15:8]);
    @(posedge clock);
  endtask
  initial
  begin
    void'($urandom(1));
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    {b, l, h} = 24'h000000;
    p = 8'h00;
    routes(1'b0);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(32'h0, rd);
    end
    apb(1'b0, 12'h014, 32'h0);
    chk(32'h2, rd);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      {b, l, h} = (i == 0) ? 24'hffffff : (i == 1) ? 24'haaaaaa : 24'($urandom);
      p = (i == 0) ? 8'hff : 8'($urandom);
      apb(1'b1, 12'h000, {24'h0, p});
      apb(1'b1, 12'h004, {24'h0, b});
      apb(1'b1, 12'h008, {24'h0, l});
      apb(1'b1, 12'h00c, {24'h0, h});
      routes(1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk({24'h0, b & 8'hcf}, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk({24'h0, l}, rd);
      apb(1'b0, 12'h00c, 32'h0);
      chk({24'h0, h & 8'h0f}, rd);
      apb(1'b0, 12'h000, 32'h0);
      chk({24'h0, p}, rd);
    end
    $display("test random done");
    b = 8'hff;
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h004, 32'hff);
    routes(1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'hcf, rd);
    apb(1'b0, 12'h014, 32'h0);
    chk(32'h3, rd);
    apb(1'b1, 12'h010, 32'h0);
    routes(1'b0);
    apb(1'b1, 12'h020, 32'hff);
    chk(32'h1, {31'h0, err});
    apb(1'b0, 12'h020, 32'h0);
    chk(32'h0, rd);
    $display("test override done");
    finishTest();
  end
endmodule
`default_nettype wire
